/* File: commissioning_test_facility_test.sv */
// Self-checking bench for the commissioning test facility.
// Assumes the AHB-Lite slave answers with hreadyout and registered read data.
module commissioning_test_facility_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, test_request, run, irq;
  logic oos, alarm, frz, cause;
  logic [31:0] haddr, hwdata, hrdata, input_state, scheme_drive, relay_drive, rd, pat;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [7:0] scheme_leds, led_drive, monitor_port, ex;
  logic [1407:0] bus;
  int miscompares = 0;
  int n_compared = 0;
  int sel[8] = '{0, 1407, 5, 700, 1060, 31, 1406, 64};
  assign hready = hreadyout;
  ctf_commission_test #(.LAMP_CYCLES(20)) ctf_commission_test_i (.hclk(hclk),
    .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .input_state(input_state), .scheme_drive(scheme_drive),
    .scheme_leds(scheme_leds), .internal_signal_bus(bus), .test_request(test_request),
    .relay_drive(relay_drive), .led_drive(led_drive), .monitor_port(monitor_port),
    .out_of_service(oos), .test_alarm(alarm), .freeze_breaker_wear_records(frz),
    .transmission_cause_test(cause), .irq(irq));
  ctf_plant ctf_plant_i (.hclk(hclk), .run(run), .internal_signal_bus(bus));
  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : cmp
  task automatic bus_op(input logic wr, input logic [7:0] a, input logic [31:0] d);
    haddr <= {24'h0, a};
    hwrite <= wr;
    hsel <= 1'b1;
    htrans <= 2'h2;
    do @(posedge hclk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hready !== 1'b1);
    rd = hrdata;
  endtask : bus_op
  // Samples after the edge see the values settled before it
  task automatic flags(input logic [31:0] e);
    repeat (4) @(posedge hclk);
    cmp("flags", e, {28'h0, oos, alarm, frz, cause});
  endtask : flags
  task automatic end_of_test();
    $display("compared %0d miscompares %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : end_of_test
  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_reset();
    bus_op(0, ctf_pkg::OFS_TEST_PATTERN, 0);
    cmp("pattern", 32'h0, rd);
    bus_op(0, ctf_pkg::OFS_SELECT_BASE + 8'h1C, 0);
    cmp("sel8", 32'h0000_0432, rd);
    bus_op(0, ctf_pkg::OFS_INPUT_STATE, 0);
    cmp("inputs", input_state, rd);
    bus_op(0, ctf_pkg::OFS_INDICATOR_STATE, 0);
    cmp("leds", {24'h0, scheme_leds}, rd);
    $display("reset and status done");
  endtask : t_reset
  task automatic t_monitor();
    for (int i = 0; i < 8; i++) bus_op(1, ctf_pkg::OFS_SELECT_BASE + 8'(4 * i), sel[i]);
    bus_op(1, ctf_pkg::OFS_SELECT_BASE, 32'h0000_0580);
    bus_op(0, ctf_pkg::OFS_SELECT_BASE, 0);
    cmp("sel1", 32'h0, rd);
    bus_op(0, ctf_pkg::OFS_PORT_STATE, 0);
    for (int i = 0; i < 8; i++) ex[i] = bus[sel[i]];
    cmp("port", {24'h0, ex}, rd);
    run <= 1'b1;
    repeat (3) @(posedge hclk);
    for (int i = 0; i < 8; i++) ex[i] = bus[(sel[i] + 1) % 1408];
    cmp("monitor", {24'h0, ex}, {24'h0, monitor_port});
    run <= 1'b0;
    $display("monitor done");
  endtask : t_monitor
  task automatic t_mode();
    pat = 32'h0000_00F0;
    bus_op(1, ctf_pkg::OFS_IRQ_MASK, 32'h1 << ctf_pkg::IRQ_ENTER);
    bus_op(1, ctf_pkg::OFS_TEST_PATTERN, pat);
    bus_op(1, ctf_pkg::OFS_TEST_MODE, {30'h0, ctf_pkg::MODE_TEST});
    flags(32'hF);
    cmp("irq on", 32'h1, {31'h0, irq});
    cmp("relay test", scheme_drive, relay_drive);
    bus_op(1, ctf_pkg::OFS_CONTACT_CMD, {30'h0, ctf_pkg::CMD_APPLY});
    flags(32'hF);
    cmp("relay apply", scheme_drive ^ pat, relay_drive);
    bus_op(0, ctf_pkg::OFS_SERVICE_STATE, 0);
    cmp("service", 32'h3, rd);
    bus_op(0, ctf_pkg::OFS_CONTACT_CMD, 0);
    cmp("cmd idle", 32'h0, rd);
    bus_op(1, ctf_pkg::OFS_TEST_MODE, {30'h0, ctf_pkg::MODE_BLOCKED});
    bus_op(1, ctf_pkg::OFS_TEST_MODE, 32'h3);
    flags(32'hF);
    cmp("relay blocked", pat, relay_drive);
    bus_op(0, ctf_pkg::OFS_OUTPUT_STATE, 0);
    cmp("out status", scheme_drive, rd);
    bus_op(1, ctf_pkg::OFS_CONTACT_CMD, {30'h0, ctf_pkg::CMD_REMOVE});
    flags(32'hF);
    cmp("relay removed", 32'h0, relay_drive);
    bus_op(1, ctf_pkg::OFS_IRQ_STATUS, 32'h1 << ctf_pkg::IRQ_ENTER);
    bus_op(1, ctf_pkg::OFS_TEST_MODE, {30'h0, ctf_pkg::MODE_DISABLED});
    flags(32'h0);
    cmp("irq masked", 32'h0, {31'h0, irq});
    cmp("relay service", scheme_drive, relay_drive);
    $display("test mode done");
  endtask : t_mode
  task automatic t_request();
    test_request <= 1'b1;
    flags(32'hF);
    test_request <= 1'b0;
    flags(32'h0);
    $display("test request done");
  endtask : t_request
  task automatic t_lamp();
    bus_op(1, ctf_pkg::OFS_LAMP_CMD, 32'h1);
    repeat (3) @(posedge hclk);
    cmp("lamp on", 32'hFF, {24'h0, led_drive});
    repeat (25) @(posedge hclk);
    cmp("lamp off", {24'h0, scheme_leds}, {24'h0, led_drive});
    bus_op(1, ctf_pkg::OFS_LAMP_CMD, 32'h0);
    repeat (3) @(posedge hclk);
    cmp("lamp idle", {24'h0, scheme_leds}, {24'h0, led_drive});
    $display("lamp check done");
  endtask : t_lamp
  // ****************************************
  // Run
  // ****************************************
  initial begin
    hclk = 1'b0;
    forever #2 hclk = ~hclk;
  end
  initial begin
    repeat (5000) @(posedge hclk);
    miscompares++;
    end_of_test();
  end
  initial begin
    {hresetn, hsel, hwrite, test_request, run, haddr, hwdata, htrans} = '0;
    hsize = 3'h2;
    input_state = 32'hA5A5_0F0F;
    scheme_drive = 32'h1234_5678;
    scheme_leds = 8'h3C;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    t_reset();
    t_monitor();
    t_mode();
    t_request();
    t_lamp();
    end_of_test();
  end
endmodule : commissioning_test_facility_test

/* File: ctf_commission_test.sv */
// Commissioning test facility: status strings, monitor port, test mode,
// contact test and indicator lamp check, all behind an AHB-Lite slave.
// Assumes all inputs are synchronous to hclk and a single bus master.
//
// Summary of operation
// RULE_01 - Report each input, 1 energized, 0 not
// RULE_02 - Report commanded output drives, 1 operated
// RULE_03 - Output status shows commands even when blocked
// RULE_04 - Port status shows the eight selected signals
// RULE_05 - Eight-bit readable lit-indicator word
// RULE_06 - Selectors take index 0 to 1407
// RULE_07 - Modes disabled, test, blocked; test raises alarm
// RULE_08 - Test freezes wear records, flags transmission cause
// RULE_09 - Plain test keeps contacts driven normally
// RULE_10 - Blocked mode drives no output relay; the code drives the forced contacts in blocked mode
// RULE_11 - Setting disabled restores service
// RULE_12 - Test request input also enters test
// RULE_13 - Pattern bit per contact, reset zero
// RULE_14 - Apply flips patterned contacts, command idles
// RULE_15 - Forced contacts hold until remove command
// RULE_16 - Lamp check lights all eight for 2 s
// RULE_17 - Monitor port follows selected signals continuously
// RULE_18 - Commands act once per write only
//
// The register addresses and register access over AHB-Lite were left to the implementer.
module ctf_commission_test #(
  parameter int N_INPUTS = 32,
  parameter int N_OUTPUTS = 32,
  parameter int N_LEDS = 8,
  parameter int N_BUS = 1408,
  parameter longint LAMP_CYCLES = ctf_pkg::LAMP_CYCLES
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic [N_INPUTS-1:0] input_state,
  input wire logic [N_OUTPUTS-1:0] scheme_drive,
  input wire logic [N_LEDS-1:0] scheme_leds,
  input wire logic [N_BUS-1:0] internal_signal_bus,
  input wire logic test_request,
  output logic [N_OUTPUTS-1:0] relay_drive,
  output logic [N_LEDS-1:0] led_drive,
  output logic [7:0] monitor_port,
  output logic out_of_service,
  output logic test_alarm,
  output logic freeze_breaker_wear_records,
  output logic transmission_cause_test,
  output logic irq
);

  // ****************************************
  // Bus slave
  // ****************************************
  localparam int SEL_W_L = ctf_pkg::SEL_W;

  logic wr_pend;
  logic rd_pend;
  logic [7:0] addr_q;
  logic [31:0] rd_word;
  logic [1:0] test_mode;
  logic [N_OUTPUTS-1:0] test_pattern;
  logic [N_OUTPUTS-1:0] forced;
  logic contact_active;
  logic [SEL_W_L-1:0] sel [8];
  logic [3:0] irq_status;
  logic [3:0] irq_mask;
  logic [31:0] lamp_cnt;
  logic lamp_on;
  logic in_test;
  logic [7:0] port_live;
  logic wr_apply;
  logic wr_remove;
  logic wr_lamp;
  logic wr_irq_clr;
  logic prev_in_test;
  logic lamp_done;

  wire logic take = hsel && hready && htrans[1];
  wire logic wr_now = wr_pend;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend <= 1'b0;
      rd_pend <= 1'b0;
      addr_q <= 8'h00;
    end else begin
      wr_pend <= take && hwrite;
      rd_pend <= take && !hwrite;
      if (take) begin
        addr_q <= haddr[7:0];
      end
    end
  end

  // Zero wait state: ready always high, OKAY always
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

  assign wr_apply = wr_now && addr_q == ctf_pkg::OFS_CONTACT_CMD
    && hwdata[1:0] == ctf_pkg::CMD_APPLY; // RULE_18
  assign wr_remove = wr_now && addr_q == ctf_pkg::OFS_CONTACT_CMD
    && hwdata[1:0] == ctf_pkg::CMD_REMOVE; // RULE_18
  assign wr_lamp = wr_now && addr_q == ctf_pkg::OFS_LAMP_CMD
    && hwdata[1:0] == ctf_pkg::CMD_APPLY; // RULE_18
  assign wr_irq_clr = wr_now && addr_q == ctf_pkg::OFS_IRQ_STATUS;

  // ****************************************
  // Settings
  // ****************************************
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      test_mode <= ctf_pkg::MODE_DISABLED;
      test_pattern <= '0; // RULE_13
      irq_mask <= ctf_pkg::IRQ_RESET;
    end else if (wr_now) begin
      if (addr_q == ctf_pkg::OFS_TEST_MODE && hwdata[1:0] != 2'h3) begin
        test_mode <= hwdata[1:0]; // RULE_07 RULE_11
      end
      if (addr_q == ctf_pkg::OFS_TEST_PATTERN) begin
        test_pattern <= hwdata[N_OUTPUTS-1:0]; // RULE_13
      end
      if (addr_q == ctf_pkg::OFS_IRQ_MASK) begin
        irq_mask <= hwdata[3:0];
      end
    end
  end

  // Out-of-range indices are refused so the selector never leaves the bus
  for (genvar i = 0; i < 8; i++) begin : g_sel
    localparam logic [7:0] OFS = ctf_pkg::OFS_SELECT_BASE + 8'(4 * i);
    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
        sel[i] <= ctf_pkg::SEL_RESET_BASE + 11'(2 * i);
      end else if (wr_now && addr_q == OFS && hwdata[10:0] <= 11'(ctf_pkg::SEL_MAX)) begin
        sel[i] <= hwdata[10:0]; // RULE_06
      end
    end
    assign port_live[i] = internal_signal_bus[sel[i]]; // RULE_04 RULE_06
  end

  // ****************************************
  // Test mode and contact test
  // ****************************************
  assign in_test = test_mode != ctf_pkg::MODE_DISABLED || test_request; // RULE_07 RULE_12

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      out_of_service <= 1'b0;
      test_alarm <= 1'b0;
      freeze_breaker_wear_records <= 1'b0;
      transmission_cause_test <= 1'b0;
      prev_in_test <= 1'b0;
    end else begin
      out_of_service <= in_test; // RULE_07 RULE_11
      test_alarm <= in_test; // RULE_07
      freeze_breaker_wear_records <= in_test; // RULE_08
      transmission_cause_test <= in_test; // RULE_08
      prev_in_test <= in_test;
    end
  end

  // Contacts flip from their scheme state while forced; in blocked mode only the forced contacts are driven
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      forced <= '0;
      contact_active <= 1'b0;
    end else if (wr_apply) begin
      forced <= test_pattern; // RULE_14
      contact_active <= 1'b1;
    end else if (wr_remove) begin
      forced <= '0; // RULE_15
      contact_active <= 1'b0;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      relay_drive <= '0;
    end else if (test_mode == ctf_pkg::MODE_BLOCKED) begin
      relay_drive <= forced; // RULE_10
    end else begin
      relay_drive <= scheme_drive ^ forced; // RULE_09 RULE_14
    end
  end

  // ****************************************
  // Lamp check and monitor port
  // ****************************************
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      lamp_cnt <= '0;
      lamp_on <= 1'b0;
    end else if (wr_lamp) begin
      lamp_cnt <= 32'(LAMP_CYCLES - 1); // RULE_16
      lamp_on <= 1'b1;
    end else if (lamp_on) begin
      if (lamp_cnt == '0) begin
        lamp_on <= 1'b0; // RULE_16
      end else begin
        lamp_cnt <= lamp_cnt - 32'h1;
      end
    end
  end
  assign lamp_done = lamp_on && lamp_cnt == '0 && !wr_lamp;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      led_drive <= '0;
      monitor_port <= 8'h00;
    end else begin
      led_drive <= lamp_on ? '1 : scheme_leds; // RULE_16
      monitor_port <= port_live; // RULE_17
    end
  end

  // ****************************************
  // Interrupts
  // ****************************************
  // A new event wins over a clear in the same cycle
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_status <= ctf_pkg::IRQ_RESET;
    end else begin
      irq_status <= (irq_status & ~(wr_irq_clr ? hwdata[3:0] : 4'h0))
        | {lamp_done, wr_apply, prev_in_test && !in_test, in_test && !prev_in_test};
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irq_status & irq_mask);
    end
  end

  // ****************************************
  // Read data
  // ****************************************
  // Decoded from the address phase so the word is ready in the data phase
  always_comb begin
    rd_word = 32'h0;
    unique case (haddr[7:0])
      ctf_pkg::OFS_INPUT_STATE: rd_word = 32'(input_state); // RULE_01
      // Blocked mode reports what service would drive, not the forced contacts
      ctf_pkg::OFS_OUTPUT_STATE: begin
        if (test_mode == ctf_pkg::MODE_BLOCKED) begin
          rd_word = 32'(scheme_drive); // RULE_03
        end else begin
          rd_word = 32'(scheme_drive ^ forced); // RULE_02
        end
      end
      ctf_pkg::OFS_PORT_STATE: rd_word = 32'(port_live); // RULE_04
      ctf_pkg::OFS_INDICATOR_STATE: rd_word = 32'(led_drive); // RULE_05
      ctf_pkg::OFS_TEST_MODE: rd_word = 32'(test_mode);
      ctf_pkg::OFS_TEST_PATTERN: rd_word = 32'(test_pattern);
      ctf_pkg::OFS_CONTACT_CMD: rd_word = 32'h0; // RULE_14 RULE_15
      ctf_pkg::OFS_LAMP_CMD: rd_word = 32'h0; // RULE_16
      ctf_pkg::OFS_IRQ_STATUS: rd_word = 32'(irq_status);
      ctf_pkg::OFS_IRQ_MASK: rd_word = 32'(irq_mask);
      ctf_pkg::OFS_SERVICE_STATE: rd_word = {29'h0, lamp_on, contact_active, in_test};
      default: begin
        for (int k = 0; k < 8; k++) begin
          if (haddr[7:0] == ctf_pkg::OFS_SELECT_BASE + 8'(4 * k)) begin
            rd_word = 32'(sel[k]);
          end
        end
      end
    endcase
  end

  // Loaded at the address phase edge and held until the next read, so the
  // status word is a snapshot taken when the read was accepted
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0;
    end else if (take && !hwrite) begin
      hrdata <= rd_word;
    end
  end

endmodule : ctf_commission_test

/* File: ctf_monitor.sv */
// Port checker for the commissioning test facility.
// Assumes it is bound into ctf_commission_test.
module ctf_monitor #(
  parameter int N_OUTPUTS = 32,
  parameter int N_LEDS = 8
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [1:0] htrans,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic [N_OUTPUTS-1:0] scheme_drive,
  input wire logic [N_LEDS-1:0] scheme_leds,
  input wire logic test_request,
  input wire logic [N_OUTPUTS-1:0] relay_drive,
  input wire logic [N_LEDS-1:0] led_drive,
  input wire logic out_of_service,
  input wire logic test_alarm,
  input wire logic freeze_breaker_wear_records,
  input wire logic transmission_cause_test
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // ****************************************
  // Port relations
  // ****************************************
  ready_okay_a: assert property (hreadyout && !hresp)
    else $error("slave not ready or not okay");
  alarm_tracks_a: assert property (test_alarm == out_of_service)
    else $error("alarm differs from out of service");
  freeze_tracks_a: assert property ($rose(out_of_service) |-> freeze_breaker_wear_records)
    else $error("wear records not frozen");
  cause_tracks_a: assert property (transmission_cause_test == out_of_service)
    else $error("transmission cause differs");
  request_enters_a: assert property (test_request |-> ##[1:3] out_of_service)
    else $error("test request ignored");
  led_follow_a: assert property ($past(hresetn) && led_drive != '1
    |-> led_drive == $past(scheme_leds))
    else $error("indicators do not follow scheme");
  lamp_holds_a: assert property ($rose(led_drive == '1) && $past(scheme_leds) != '1
    |-> (led_drive == '1) [*8])
    else $error("lamp check too short");
  relay_follow_a: assert property ($past(hresetn) && !out_of_service && !$past(out_of_service)
    |-> relay_drive == $past(scheme_drive))
    else $error("relays do not follow scheme in service");
  rdata_hold_a: assert property (!$past(hsel && htrans[1]) && !$past(hsel && htrans[1], 2)
    |-> $stable(hrdata))
    else $error("read data moved without transfer");
endmodule : ctf_monitor

bind ctf_commission_test ctf_monitor #(.N_OUTPUTS(N_OUTPUTS), .N_LEDS(N_LEDS)) ctf_monitor_i (
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .htrans(htrans), .hrdata(hrdata),
  .hreadyout(hreadyout), .hresp(hresp), .scheme_drive(scheme_drive),
  .scheme_leds(scheme_leds), .test_request(test_request), .relay_drive(relay_drive),
  .led_drive(led_drive), .out_of_service(out_of_service), .test_alarm(test_alarm),
  .freeze_breaker_wear_records(freeze_breaker_wear_records),
  .transmission_cause_test(transmission_cause_test));

/* File: ctf_pkg.sv */
// Constants for the commissioning test facility.
// Assumes a 250 MHz bus clock and a 32-bit AHB-Lite register bus.
package ctf_pkg;

  // ****************************************
  // Register byte offsets
  // ****************************************
  localparam logic [7:0] OFS_INPUT_STATE = 8'h00;
  localparam logic [7:0] OFS_OUTPUT_STATE = 8'h04;
  localparam logic [7:0] OFS_PORT_STATE = 8'h08;
  localparam logic [7:0] OFS_INDICATOR_STATE = 8'h0C;
  localparam logic [7:0] OFS_SELECT_BASE = 8'h10;
  localparam logic [7:0] OFS_TEST_MODE = 8'h30;
  localparam logic [7:0] OFS_TEST_PATTERN = 8'h34;
  localparam logic [7:0] OFS_CONTACT_CMD = 8'h38;
  localparam logic [7:0] OFS_LAMP_CMD = 8'h3C;
  localparam logic [7:0] OFS_IRQ_STATUS = 8'h40;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h44;
  localparam logic [7:0] OFS_SERVICE_STATE = 8'h48;

  // ****************************************
  // Field encodings and reset values
  // ****************************************
  localparam logic [1:0] MODE_DISABLED = 2'h0;
  localparam logic [1:0] MODE_TEST = 2'h1;
  localparam logic [1:0] MODE_BLOCKED = 2'h2;
  localparam logic [1:0] CMD_NOP = 2'h0;
  localparam logic [1:0] CMD_APPLY = 2'h1;
  localparam logic [1:0] CMD_REMOVE = 2'h2;
  localparam int SEL_W = 11;
  localparam int SEL_MAX = 1407;
  localparam logic [10:0] SEL_RESET_BASE = 11'h424;
  localparam logic [3:0] IRQ_RESET = 4'h0;
  // Interrupt bits: test entered, test left, contacts applied, lamp check done
  localparam int IRQ_ENTER = 0;
  localparam int IRQ_LEAVE = 1;
  localparam int IRQ_CONTACT = 2;
  localparam int IRQ_LAMP = 3;

  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_MHZ = 250;
  localparam int LAMP_MS = 2000;
  localparam longint LAMP_CYCLES = longint'(LAMP_MS) * 1000 * CLK_MHZ;

endpackage : ctf_pkg

/* File: ctf_plant.sv */
// Far-side model: the relay's live internal signal bus.
// Assumes one clock; run lets the bus rotate every cycle.
module ctf_plant (
  input wire logic hclk,
  input wire logic run,
  output logic [1407:0] internal_signal_bus
);
  timeunit 1ns;
  timeprecision 1ps;
  // ****************************************
  // Signal pattern
  // ****************************************
  initial internal_signal_bus = {88{16'hA5C3}};
  // Rotating, so a latched monitor output would be caught
  always @(posedge hclk) begin
    if (run) begin
      internal_signal_bus <= {internal_signal_bus[1406:0], internal_signal_bus[1407]};
    end
  end
endmodule : ctf_plant
